/* bench/spsf_far_end.sv */
// Remote serial device that frames bytes onto the receive line and decodes the transmit line.
`timescale 1ns/1ps
module spsf_far_end (
  input  wire logic clk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  logic [7:0] heard [$];
  logic [7:0] sh;
  // The line idles high between frames, as a real remote end leaves it.
  initial rx_o = 1'b1;
  // Sends 11 bits LSB first at 16 clocks a bit; a spike upsets one sample of the first data bit.
  task automatic send(input logic [10:0] f, input bit spike);
    for (int i = 0; i < 11; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clk_i);
        rx_o <= (spike && i == 1 && c == 10) ? ~f[i] : f[i];
      end
    end
    @(posedge clk_i);
    rx_o <= 1'b1;
  endtask : send
  // Samples each transmitted data bit at its middle and skips parity and stop.
  initial forever begin
    @(negedge tx_i);
    repeat (24) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      sh[i] = tx_i;
      repeat (16) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    heard.push_back(sh);
  end
endmodule : spsf_far_end

/* bench/spsf_top_tb_top.sv */
// Self-checking bench for the serial port status flag block.
`timescale 1ns/1ps
module spsf_top_tb_top;
  import spsf_pkg::*;
  localparam logic [7:0] TBL [3] = '{OFS_CTL2, OFS_GUARD, OFS_CTL3};
  logic              clk_i, rst_i, cyc, stb, we, ack, rx, tx, irq, cts_n;
  logic [ADDR_W-1:0] adr;
  logic [3:0]        sel;
  logic [31:0]       wdat, rdat, q, r, seed;
  logic [7:0]        b [3];
  int                err_total, total_checks;

  spsf_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rx_i(rx), .tx_o(tx), .clear_to_send_n_i(cts_n), .irq_o(irq));
  spsf_far_end pm_u (.clk_i(clk_i), .tx_i(tx), .rx_o(rx));

  // Free-running 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // Compares one observed value with its expectation.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; the wait is bounded so a silent slave counts as a mismatch.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (ack !== 1'b1) err_total++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // Reads a register and compares the masked value.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd_chk

  // Repeatable xorshift source.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Builds start, data, even parity (optionally wrong) and stop.
  function automatic logic [10:0] fr(input logic [7:0] d, input logic bad);
    return {1'b1, ^d ^ bad, d, 1'b0};
  endfunction : fr

  // Watchdog sized well beyond the expected few thousand cycles.
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    close_out();
  end

  // Main sequence.
  initial begin
    {rst_i, cyc, stb, we, cts_n} = 5'h10;
    {adr, sel, wdat} = '0;
    seed = 32'h3F5D;
    err_total = 0;
    total_checks = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    sel <= 4'hF;
    @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'hFFFFFFFF, 32'h000000C0);
    wb(1'b1, 8'h24, xs());
    rd_chk(8'h24, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 3; i++) begin
      r = xs() & 32'hFFFFFDFF;
      wb(1'b1, TBL[i], r);
      rd_chk(TBL[i], 32'hFFFFFFFF, r & 32'hFFFF);
    end
    wb(1'b1, OFS_BAUD, 32'h10);
    rd_chk(OFS_BAUD, 32'hFFFFFFFF, 32'h10);
    wb(1'b1, OFS_CTL3, 32'h0);
    wb(1'b1, OFS_CTL1, 32'h40C);
    for (int i = 0; i < 3; i++) begin
      r = xs();
      b[i] = r[7:0];
    end
    // Back-to-back words: the second waits in the data register while the first shifts out.
    wb(1'b1, OFS_DATA, {24'h0, b[0]});
    wb(1'b1, OFS_DATA, {24'h0, b[1]});
    rd_chk(OFS_STATUS, 32'hC0, 32'h0);
    for (int n = 0; n < 1000 && pm_u.heard.size() < 2; n++) @(posedge clk_i);
    repeat (40) @(posedge clk_i);
    chk(32'(pm_u.heard.size()), 32'h2);
    chk({24'h0, pm_u.heard[0]}, {24'h0, b[0]});
    chk({24'h0, pm_u.heard[1]}, {24'h0, b[1]});
    rd_chk(OFS_STATUS, 32'hC0, 32'hC0);
    wb(1'b1, OFS_DATA, {24'h0, b[2]});
    rd_chk(OFS_STATUS, 32'h40, 32'h0);
    // Received frame with a wrong parity bit.
    pm_u.send(fr(b[0], 1'b1), 1'b0);
    repeat (24) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h3F, 32'h21);
    rd_chk(OFS_DATA, 32'hFF, {24'h0, b[0]});
    rd_chk(OFS_STATUS, 32'h3F, 32'h0);
    repeat (200) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h10, 32'h10);
    wb(1'b0, OFS_DATA, 32'h0);
    // A noisy frame followed by a second one before the first is read.
    pm_u.send(fr(b[1], 1'b0), 1'b1);
    pm_u.send(fr(b[2], 1'b0), 1'b0);
    repeat (24) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h3F, 32'h2C);
    rd_chk(OFS_DATA, 32'hFF, {24'h0, b[1]});
    // Break: all zeros including stop; writing zero clears only the write-zero bits.
    pm_u.send(11'h000, 1'b0);
    repeat (24) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h102, 32'h102);
    wb(1'b1, OFS_STATUS, 32'h0);
    rd_chk(OFS_STATUS, 32'h162, 32'h002);
    // Flow-control pin toggles, first with the enable off.
    cts_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h200, 32'h0);
    wb(1'b1, OFS_CTL3, 32'h200);
    cts_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h200, 32'h200);
    wb(1'b1, OFS_MASK, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, OFS_MASK, 32'h200);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, OFS_EVENT, 32'h3FF);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, OFS_STATUS, 32'h0);
    rd_chk(OFS_STATUS, 32'h200, 32'h0);
    // Odd parity: a frame with a correct odd parity bit must not raise the parity flag.
    wb(1'b1, OFS_CTL1, 32'h60C);
    pm_u.send(fr(b[2], 1'b1), 1'b0);
    repeat (24) @(posedge clk_i);
    rd_chk(OFS_STATUS, 32'h21, 32'h20);
    rd_chk(OFS_DATA, 32'hFF, {24'h0, b[2]});
    close_out();
  end
endmodule : spsf_top_tb_top

/* logic/spsf_top.sv */
// Serial port with status flags, register file and Wishbone slave.
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
module spsf_top (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [spsf_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     rx_i,
  output logic                          tx_o,
  input  wire logic                     clear_to_send_n_i,
  output logic                          irq_o
);
  import spsf_pkg::*;

  logic [ST_W-1:0] status;
  logic [ST_W-1:0] events;
  logic [15:0]     irq_mask;
  logic [15:0]     baud_divider;
  logic [15:0]     control_one;
  logic [15:0]     control_two;
  logic [15:0]     control_three;
  logic [15:0]     guard_time_prescale;
  logic [ST_W-1:0] set_vec;
  logic [ST_W-1:0] clr_vec;
  logic [ST_W-1:0] lane_mask;
  logic [31:0]     next_rdat;
  logic            req;
  logic            rd_status;
  logic            rd_data;
  logic            wr_data;
  logic            wr_status;
  logic            seen;
  logic            seen_rxne;
  logic            clr_err;
  logic            clr_pe;
  logic            clr_tc_seq;
  logic            unmapped;
  logic            rx_meta;
  logic            rx_s;
  logic            cts_meta;
  logic            cts_s;
  logic            cts_d;
  logic            cts_en;
  logic            par_en;
  logic [15:0]     period;
  logic [15:0]     half;
  spsf_rx_t        rx_state;
  logic [15:0]     rx_cnt;
  logic [3:0]      rx_idx;
  logic [7:0]      rx_shift;
  logic [7:0]      rx_hold;
  logic            rx_par;
  logic            rx_s0;
  logic            rx_s1;
  logic            rx_noise;
  logic            rx_eval;
  logic            rx_vote;
  logic            rx_last;
  logic            rx_done;
  logic            noise_now;
  logic            stop_bad;
  logic            par_fail;
  logic            brk;
  logic [19:0]     idle_cnt;
  logic [19:0]     idle_len;
  logic            idle_armed;
  logic            idle_pulse;
  spsf_tx_t        tx_state;
  logic [15:0]     tx_cnt;
  logic [3:0]      tx_bit;
  logic [10:0]     tx_frame;
  logic [7:0]      tx_buf;
  logic            tx_go;
  logic            tx_load;
  logic            tx_done;
  logic            tx_end_bit;

  // Byte-lane merge for the plain read-write registers.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // Address check behind the unmapped flag used by the reserved-zero assertion.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_STATUS) || (a == OFS_DATA) || (a == OFS_BAUD) ||
                (a == OFS_CTL1) || (a == OFS_CTL2) || (a == OFS_CTL3) ||
                (a == OFS_GUARD) || (a == OFS_EVENT) || (a == OFS_MASK);
  endfunction : is_mapped

  // One access per request; ack is dropped the cycle after it is given.
  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_status = req && !wb_we_i && (wb_adr_i == OFS_STATUS);
  assign rd_data   = req && !wb_we_i && (wb_adr_i == OFS_DATA);
  assign wr_data   = req && wb_we_i && (wb_adr_i == OFS_DATA) && wb_sel_i[0];
  assign wr_status = req && wb_we_i && (wb_adr_i == OFS_STATUS);
  assign unmapped  = !is_mapped(wb_adr_i);
  assign lane_mask = {{2{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // The two-step clearing sequences are remembered across accesses.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen      <= 1'b0;
      seen_rxne <= 1'b0;
    end else if (rd_status) begin
      seen      <= 1'b1;
      seen_rxne <= status[B_RXNE];
    end else if (rd_data || wr_data) begin
      seen      <= 1'b0;
    end
  end

  assign clr_err    = rd_data && seen;
  assign clr_pe     = clr_err && seen_rxne;
  assign clr_tc_seq = wr_data && seen;

  // Bus acknowledge, one cycle after the request is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read mux; an unmapped address answers with zero.
  always_comb begin
    next_rdat = 32'h0000_0000;
    if (wb_adr_i == OFS_STATUS) begin
      next_rdat = {22'h00_0000, status};
    end else if (wb_adr_i == OFS_DATA) begin
      next_rdat = {24'h00_0000, rx_hold};
    end else if (wb_adr_i == OFS_BAUD) begin
      next_rdat = {16'h0000, baud_divider};
    end else if (wb_adr_i == OFS_CTL1) begin
      next_rdat = {16'h0000, control_one};
    end else if (wb_adr_i == OFS_CTL2) begin
      next_rdat = {16'h0000, control_two};
    end else if (wb_adr_i == OFS_CTL3) begin
      next_rdat = {16'h0000, control_three};
    end else if (wb_adr_i == OFS_GUARD) begin
      next_rdat = {16'h0000, guard_time_prescale};
    end else if (wb_adr_i == OFS_EVENT) begin
      next_rdat = {22'h00_0000, events};
    end else if (wb_adr_i == OFS_MASK) begin
      next_rdat = {22'h00_0000, irq_mask[ST_W-1:0]};
    end
  end

  // Read data is held until the next read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= next_rdat;
    end
  end

  // Plain configuration registers with byte lanes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_divider        <= REG_RESET;
      control_one         <= REG_RESET;
      control_two         <= REG_RESET;
      control_three       <= REG_RESET;
      guard_time_prescale <= REG_RESET;
      irq_mask            <= REG_RESET;
    end else if (req && wb_we_i) begin
      if (wb_adr_i == OFS_BAUD) begin
        baud_divider <= merge16(baud_divider, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_CTL1) begin
        control_one <= merge16(control_one, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_CTL2) begin
        control_two <= merge16(control_two, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_CTL3) begin
        control_three <= merge16(control_three, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_GUARD) begin
        guard_time_prescale <= merge16(guard_time_prescale, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == OFS_MASK) begin
        irq_mask <= merge16(irq_mask, wb_dat_i, wb_sel_i) & 16'h03FF;
      end
    end
  end

  // Transmit holding word, written through the data window.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_buf <= 8'h00;
    end else if (wr_data) begin
      tx_buf <= wb_dat_i[7:0];
    end
  end

  // Pins from the far side pass two flops before use.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_meta  <= 1'b1;
      rx_s     <= 1'b1;
      cts_meta <= 1'b1;
      cts_s    <= 1'b1;
      cts_d    <= 1'b1;
    end else begin
      rx_meta  <= rx_i;
      rx_s     <= rx_meta;
      cts_meta <= clear_to_send_n_i;
      cts_s    <= cts_meta;
      cts_d    <= cts_s;
    end
  end

  // Bit period in clocks; tiny divisors are raised so three samples fit.
  assign period = (baud_divider < MIN_PERIOD) ? MIN_PERIOD : baud_divider;
  assign half   = {1'b0, period[15:1]};
  assign par_en = control_one[C1_PAR_EN];
  assign cts_en = control_three[C3_CTS_EN];

  // Three samples around mid-bit are voted; any disagreement is noise.
  assign rx_eval   = (rx_state == RX_BUSY) && (rx_cnt == half + 16'h0001);
  assign rx_vote   = (rx_s0 & rx_s1) | (rx_s0 & rx_s) | (rx_s1 & rx_s);
  assign noise_now = rx_noise | (rx_s0 != rx_s1) | (rx_s1 != rx_s);
  assign rx_last   = rx_idx == (par_en ? DATA_BITS + 4'h2 : DATA_BITS + 4'h1);
  assign rx_done   = rx_eval && rx_last;
  assign stop_bad  = !rx_vote;
  assign par_fail  = par_en && ((^rx_shift ^ rx_par) != control_one[C1_PAR_ODD]);
  assign brk       = (rx_shift == 8'h00) && !rx_vote && !(par_en && rx_par);

  // Receiver: start, data bits LSB first, optional parity, stop.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 16'h0000;
      rx_idx   <= 4'h0;
      rx_shift <= 8'h00;
      rx_par   <= 1'b0;
      rx_s0    <= 1'b1;
      rx_s1    <= 1'b1;
      rx_noise <= 1'b0;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          rx_cnt   <= 16'h0000;
          rx_idx   <= 4'h0;
          rx_noise <= 1'b0;
          if (control_one[C1_RX_EN] && !rx_s) begin
            rx_state <= RX_BUSY;
          end
        end
        RX_BUSY: begin
          rx_cnt <= (rx_cnt == period - 16'h0001) ? 16'h0000 : rx_cnt + 16'h0001;
          if (rx_cnt == period - 16'h0001) begin
            rx_idx <= rx_idx + 4'h1;
          end
          if (rx_cnt == half - 16'h0001) begin
            rx_s0 <= rx_s;
          end
          if (rx_cnt == half) begin
            rx_s1 <= rx_s;
          end
          if (rx_eval) begin
            rx_noise <= noise_now;
            if (rx_idx == 4'h0 && rx_vote) begin
              rx_state <= RX_IDLE;  // A glitch, not a start bit.
            end else if (rx_idx >= 4'h1 && rx_idx <= DATA_BITS) begin
              rx_shift <= {rx_vote, rx_shift[7:1]};
            end else if (rx_idx == DATA_BITS + 4'h1 && par_en) begin
              rx_par <= rx_vote;
            end
            if (rx_last) begin
              rx_state <= RX_IDLE;  // Resync at mid stop bit.
            end
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // An overrun keeps the unread word; the new frame is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_hold <= 8'h00;
    end else if (rx_done && !status[B_RXNE]) begin
      rx_hold <= rx_shift;
    end
  end

  // Idle is ten bit periods of high line after a received frame, once per gap.
  assign idle_len   = 20'({period, 3'b000}) + 20'({period, 1'b0});
  assign idle_pulse = idle_armed && rx_s && (rx_state == RX_IDLE) && (idle_cnt == idle_len - 20'h00001);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt   <= 20'h00000;
      idle_armed <= 1'b0;
    end else begin
      if (rx_done) begin
        idle_armed <= 1'b1;
      end else if (idle_pulse) begin
        idle_armed <= 1'b0;
      end
      if (!rx_s || rx_state != RX_IDLE || idle_pulse) begin
        idle_cnt <= 20'h00000;
      end else if (idle_armed) begin
        idle_cnt <= idle_cnt + 20'h00001;
      end
    end
  end

  // Transmit starts only with a full buffer and, if enabled, the far side ready.
  assign tx_go      = (tx_state == TX_IDLE) && control_one[C1_TX_EN] && !status[B_TXE] &&
                      (!cts_en || !cts_s);
  assign tx_load    = tx_go;
  assign tx_end_bit = (tx_state == TX_BUSY) && (tx_cnt == period - 16'h0001);
  assign tx_done    = tx_end_bit && (tx_bit == (par_en ? 4'hA : 4'h9));

  // Transmitter shifts start, data, optional parity and stop out.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_state <= TX_IDLE;
      tx_cnt   <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_frame <= 11'h7FF;
      tx_o     <= 1'b1;
    end else begin
      tx_o <= (tx_state == TX_BUSY) ? tx_frame[0] : 1'b1;
      case (tx_state)
        TX_IDLE: begin
          tx_cnt <= 16'h0000;
          tx_bit <= 4'h0;
          if (tx_go) begin
            tx_frame <= {1'b1, par_en ? (^tx_buf ^ control_one[C1_PAR_ODD]) : 1'b1, tx_buf, 1'b0};
            tx_state <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          tx_cnt <= tx_end_bit ? 16'h0000 : tx_cnt + 16'h0001;
          if (tx_end_bit) begin
            tx_frame <= {1'b1, tx_frame[10:1]};
            tx_bit   <= tx_bit + 4'h1;
          end
          if (tx_done) begin
            tx_state <= TX_IDLE;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Hardware events that raise status bits.
  always_comb begin
    set_vec         = '0;
    set_vec[B_PE]   = rx_done && par_fail;
    set_vec[B_FE]   = rx_done && stop_bad;
    set_vec[B_NE]   = rx_done && noise_now;
    set_vec[B_ORE]  = rx_done && status[B_RXNE];
    set_vec[B_IDLE] = idle_pulse;
    set_vec[B_RXNE] = rx_done && !status[B_RXNE];
    set_vec[B_TC]   = tx_done && status[B_TXE];
    set_vec[B_TXE]  = tx_load;
    set_vec[B_LBD]  = rx_done && brk;
    set_vec[B_CTS]  = cts_en && (cts_s != cts_d);
  end

  // Software clears; write-zero acts only on its own bits and byte lanes.
  always_comb begin
    clr_vec         = wr_status ? (~wb_dat_i[ST_W-1:0] & ST_W0C & lane_mask) : '0;
    clr_vec[B_PE]   = clr_pe;
    clr_vec[B_FE]   = clr_err;
    clr_vec[B_NE]   = clr_err;
    clr_vec[B_ORE]  = clr_err;
    clr_vec[B_IDLE] = clr_err;
    clr_vec[B_RXNE] = clr_vec[B_RXNE] | rd_data;
    clr_vec[B_TC]   = clr_vec[B_TC] | clr_tc_seq;
    clr_vec[B_TXE]  = wr_data;
  end

  // A set in the same cycle as a clear wins, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= ST_RESET;
    end else begin
      status <= set_vec | (status & ~clr_vec);
    end
  end

  // Sticky event copy for interrupts, cleared by writing ones.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      events <= '0;
    end else if (req && wb_we_i && wb_adr_i == OFS_EVENT) begin
      events <= set_vec | (events & ~(wb_dat_i[ST_W-1:0] & lane_mask));
    end else begin
      events <= set_vec | events;
    end
  end

  // Single level interrupt from all unmasked events.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(events & irq_mask[ST_W-1:0]);
    end
  end

  parity_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rx_done && par_fail |=> status[B_PE])
    else $error("parity flag not raised");

  frame_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rx_done && !rx_vote |=> status[B_FE])
    else $error("framing flag not raised");

  noise_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rx_done && noise_now |=> status[B_NE])
    else $error("noise flag not raised");

  overrun_keep_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rx_done && status[B_RXNE] |=> status[B_ORE] && $stable(rx_hold))
    else $error("overrun not flagged or word overwritten");

  rxne_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rx_done && !status[B_RXNE] |=> status[B_RXNE] && rx_hold == $past(rx_shift))
    else $error("receive word not loaded");

  rxne_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rd_data && !set_vec[B_RXNE] |=> !status[B_RXNE])
    else $error("data read did not clear receive flag");

  err_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i) rd_status ##1 (!req [*2]) ##1 (rd_data && !rx_done)
    |=> !status[B_FE] && !status[B_NE] && !status[B_ORE])
    else $error("status then data read left errors set");

  tc_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i) tx_done && status[B_TXE] |=> status[B_TC] && tx_state == TX_IDLE)
    else $error("transmit complete not raised");

  tc_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i) clr_tc_seq && !set_vec[B_TC] |=> !status[B_TC])
    else $error("transmit complete not cleared");

  txe_load_a: assert property (
    @(posedge clk_i) disable iff (rst_i) tx_load |=> status[B_TXE] && tx_state == TX_BUSY ##1 !tx_o)
    else $error("shifter load did not empty buffer");

  txe_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i) wr_data && !tx_load |=> !status[B_TXE])
    else $error("data write did not fill buffer");

  cts_change_a: assert property (
    @(posedge clk_i) disable iff (rst_i) cts_en && $changed(cts_d) |-> status[B_CTS])
    else $error("flow input change not flagged");

  irq_level_a: assert property (
    @(posedge clk_i) disable iff (rst_i) |(events & irq_mask[ST_W-1:0]) |=> irq_o)
    else $error("interrupt not raised");

  reserved_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i) req && !wb_we_i && (rd_status || unmapped) |=>
    wb_ack_o && wb_dat_o[31:ST_W] == 22'h00_0000)
    else $error("reserved status bits not zero");

endmodule : spsf_top

/* pkg/spsf_pkg.sv */
// Constants, types and register map of the serial port status flag block.
// What this block does
// - Failed parity check sets status bit 0.
// - Bad stop bit or break sets bit 1.
// - Noisy received frame sets status bit 2.
// - Frame arriving while data unread sets bit 3.
// - Idle receive line sets status bit 4.
// - Status read then data read clears errors.
// - Receive data register load sets bit 5.
// - Data read or writing zero clears bit 5.
// - Last frame sent, buffer empty sets bit 6.
// - Status read then data write, or zero clears 6.
// - Shifter taking transmit word sets bit 7.
// - Writing the data register clears bit 7.
// - Break sets bit 8; writing zero clears.
// - Enabled flow input toggle sets bit 9.
// - Nine registers decoded at word offsets.
// - Enabled events ORed onto one interrupt.
package spsf_pkg;
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_DATA     = 8'h04;
  localparam logic [7:0] OFS_BAUD     = 8'h08;
  localparam logic [7:0] OFS_CTL1     = 8'h0C;
  localparam logic [7:0] OFS_CTL2     = 8'h10;
  localparam logic [7:0] OFS_CTL3     = 8'h14;
  localparam logic [7:0] OFS_GUARD    = 8'h18;
  localparam logic [7:0] OFS_EVENT    = 8'h1C;
  localparam logic [7:0] OFS_MASK     = 8'h20;
  localparam int         ST_W         = 10;
  localparam int         B_PE         = 0;
  localparam int         B_FE         = 1;
  localparam int         B_NE         = 2;
  localparam int         B_ORE        = 3;
  localparam int         B_IDLE       = 4;
  localparam int         B_RXNE       = 5;
  localparam int         B_TC         = 6;
  localparam int         B_TXE        = 7;
  localparam int         B_LBD        = 8;
  localparam int         B_CTS        = 9;
  localparam logic [9:0] ST_RESET     = 10'h0C0;
  localparam logic [9:0] ST_W0C       = 10'h360;
  localparam int         C1_RX_EN     = 2;
  localparam int         C1_TX_EN     = 3;
  localparam int         C1_PAR_ODD   = 9;
  localparam int         C1_PAR_EN    = 10;
  localparam int         C3_CTS_EN    = 9;
  localparam logic [15:0] REG_RESET   = 16'h0000;
  localparam logic [15:0] MIN_PERIOD  = 16'h0010;
  localparam logic [3:0] DATA_BITS    = 4'h8;

  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_BUSY = 2'b10} spsf_rx_t;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_BUSY = 2'b10} spsf_tx_t;
endpackage : spsf_pkg
